//--- rtl/ckd_pkg.sv
// Package with the constants, state types and the helper function of the clock driver control.
package ckd_pkg;
   // Configuration register width and field positions.
   localparam int CFG_W = 3;
   localparam int CFG_BYPASS = 0;      // Loop bypass request, configuration bit 57.
   localparam int CFG_LEVEL = 1;       // Gated stop level, configuration bit 58.
   localparam int CFG_GATE = 2;        // Gated stop style, configuration bit 59.
   localparam logic [CFG_W-1:0] CFG_RST = 3'h0;

   // Test access port instruction register.
   localparam int IR_W = 4;
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;   // Fixed pattern captured into the shifter.
   localparam logic [IR_W-1:0] IR_CFG = 4'h2;       // Selects the configuration data register.
   localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;    // Selects the one-bit bypass register.

   // Serial bus slave address; the upper part is arbitrary, the lower two bits come from pins.
   localparam logic [4:0] I2C_ADDR_HI = 5'h0d;
   localparam logic [3:0] BIT_CNT_BYTE = 4'h8;
   localparam logic [3:0] BIT_CNT_ZERO = 4'h0;

   // Positions of the pin inputs inside the synchroniser vector.
   localparam int SY_TCLK = 0;
   localparam int SY_TMS = 1;
   localparam int SY_TDI = 2;
   localparam int SY_TRST = 3;
   localparam int SY_SEL = 4;
   localparam int SY_SCL = 5;
   localparam int SY_SDA = 6;
   localparam int SY_LOOP = 7;
   localparam int SY_PD = 8;
   localparam int SY_STOP = 9;
   localparam int SY_IDB = 10;
   localparam int SY_IDA = 11;
   localparam int SY_REF = 12;
   localparam int SY_PLL = 13;
   localparam int SY_LOCK = 14;
   localparam int SY_DIS = 15;
   localparam int SY_W = 16;
   localparam logic [SY_W-1:0] SY_INIT = 16'h0060;   // Serial clock and data idle high.

   // Test access port controller states.
   typedef enum logic [15:0] {
      TAP_TLR = 16'h0001, TAP_RTI = 16'h0002, TAP_SELDR = 16'h0004, TAP_CAPDR = 16'h0008,
      TAP_SHDR = 16'h0010, TAP_EX1DR = 16'h0020, TAP_PDR = 16'h0040, TAP_EX2DR = 16'h0080,
      TAP_UPDR = 16'h0100, TAP_SELIR = 16'h0200, TAP_CAPIR = 16'h0400, TAP_SHIR = 16'h0800,
      TAP_EX1IR = 16'h1000, TAP_PIR = 16'h2000, TAP_EX2IR = 16'h4000, TAP_UPIR = 16'h8000
   } ckd_tap_e;

   // Serial bus slave states.
   typedef enum logic [4:0] {
      I2C_IDLE = 5'h01, I2C_ADDR = 5'h02, I2C_ACKA = 5'h04, I2C_DATA = 5'h08, I2C_ACKD = 5'h10
   } ckd_i2c_e;

   // Next state of the test access port controller for a given mode select level.
   function automatic ckd_tap_e ckd_tap_next(input ckd_tap_e s, input logic m);
      case (s)
         TAP_TLR: ckd_tap_next = m ? TAP_TLR : TAP_RTI;
         TAP_RTI: ckd_tap_next = m ? TAP_SELDR : TAP_RTI;
         TAP_SELDR: ckd_tap_next = m ? TAP_SELIR : TAP_CAPDR;
         TAP_CAPDR: ckd_tap_next = m ? TAP_EX1DR : TAP_SHDR;
         TAP_SHDR: ckd_tap_next = m ? TAP_EX1DR : TAP_SHDR;
         TAP_EX1DR: ckd_tap_next = m ? TAP_UPDR : TAP_PDR;
         TAP_PDR: ckd_tap_next = m ? TAP_EX2DR : TAP_PDR;
         TAP_EX2DR: ckd_tap_next = m ? TAP_UPDR : TAP_SHDR;
         TAP_UPDR: ckd_tap_next = m ? TAP_SELDR : TAP_RTI;
         TAP_SELIR: ckd_tap_next = m ? TAP_TLR : TAP_CAPIR;
         TAP_CAPIR: ckd_tap_next = m ? TAP_EX1IR : TAP_SHIR;
         TAP_SHIR: ckd_tap_next = m ? TAP_EX1IR : TAP_SHIR;
         TAP_EX1IR: ckd_tap_next = m ? TAP_UPIR : TAP_PIR;
         TAP_PIR: ckd_tap_next = m ? TAP_EX2IR : TAP_PIR;
         TAP_EX2IR: ckd_tap_next = m ? TAP_UPIR : TAP_SHIR;
         TAP_UPIR: ckd_tap_next = m ? TAP_SELDR : TAP_RTI;
         default: ckd_tap_next = TAP_TLR;
      endcase
   endfunction : ckd_tap_next
endpackage : ckd_pkg

//--- rtl/ckd_sync.sv
// Three-stage pin synchroniser with a stability filter on the last two stages.
`timescale 1ns/1ps
module ckd_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rstn,
   // Raw pins and their filtered copy.
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_reg;   // First stage, read only by the second.
   logic [W-1:0] s2_reg;   // Second stage.
   logic [W-1:0] s3_reg;   // Third stage.

   // Shift the pins through the three stages.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         s1_reg <= INIT;
         s2_reg <= INIT;
         s3_reg <= INIT;
      end else begin
         s1_reg <= d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // A bit takes its new value only once the second and third stages agree.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         q <= INIT;
      end else begin
         for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               q[i] <= s3_reg[i];
            end
         end
      end
   end
endmodule : ckd_sync

//--- rtl/ckd_top.sv
// Control logic of the programmable loop clock driver: stop style, bypass, lock and programming.
`timescale 1ns/1ps
module ckd_top (
   // Clock and reset.
   input wire logic mclk,
   input wire logic rstn,
   // Board control pins.
   input wire logic loop_enable,
   input wire logic power_down_n,
   input wire logic stop_style_ctl,
   input wire logic out_disable,
   // Clock sources and loop status from the analog core.
   input wire logic ref_clk,
   input wire logic pll_clk,
   input wire logic pll_locked,
   // Programming pins shared between scan and serial bus.
   input wire logic trst_n,
   input wire logic if_sel,
   input wire logic tclk,
   input wire logic tms,
   input wire logic tdi,
   input wire logic bus_id_pin_b,
   input wire logic bus_id_pin_a,
   output logic tdo_out,
   output logic tdo_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Clock outputs and their common enable.
   output logic true_clk_out,
   output logic inverted_clk_out,
   output logic feedback_clk_out,
   output logic feedback_inv_out,
   output logic clk_oe,
   // Loop control and status.
   output logic pll_enable,
   output logic input_enable,
   output logic lock_out,
   output logic [ckd_pkg::CFG_W-1:0] cfg_state
);
   import ckd_pkg::*;

   logic [SY_W-1:0] pin_vec;   // Raw pins gathered for the synchroniser.
   logic [SY_W-1:0] pin_s;     // Filtered pins in the mclk domain.
   logic tclk_d_reg;           // Previous filtered test clock.
   logic scl_d_reg;            // Previous filtered serial clock.
   logic sda_d_reg;            // Previous filtered serial data.
   ckd_tap_e tap_reg;          // Test controller state.
   logic [IR_W-1:0] ir_sh_reg; // Instruction shifter.
   logic [IR_W-1:0] ir_reg;    // Active instruction.
   logic [CFG_W-1:0] dr_sh_reg;// Configuration data shifter.
   logic byp_reg;              // Bypass bit.
   logic [CFG_W-1:0] cfg_reg;  // Configuration bits 57 to 59.
   ckd_i2c_e i2c_reg;          // Serial bus slave state.
   logic [3:0] bcnt_reg;       // Bits received in the current byte.
   logic [7:0] i2c_sh_reg;     // Serial bus receive shifter.

   assign pin_vec[SY_TCLK] = tclk;
   assign pin_vec[SY_TMS] = tms;
   assign pin_vec[SY_TDI] = tdi;
   assign pin_vec[SY_TRST] = trst_n;
   assign pin_vec[SY_SEL] = if_sel;
   assign pin_vec[SY_SCL] = tclk;      // The test clock pin doubles as the serial clock.
   assign pin_vec[SY_SDA] = sda_in;
   assign pin_vec[SY_LOOP] = loop_enable;
   assign pin_vec[SY_PD] = power_down_n;
   assign pin_vec[SY_STOP] = stop_style_ctl;
   assign pin_vec[SY_IDB] = bus_id_pin_b;
   assign pin_vec[SY_IDA] = bus_id_pin_a;
   assign pin_vec[SY_REF] = ref_clk;
   assign pin_vec[SY_PLL] = pll_clk;
   assign pin_vec[SY_LOCK] = pll_locked;
   assign pin_vec[SY_DIS] = out_disable;

   // Every pin crosses into the mclk domain through the filtered synchroniser.
   ckd_sync #(.W(SY_W), .INIT(SY_INIT)) u_sync (
      .mclk(mclk),
      .rstn(rstn),
      .d(pin_vec),
      .q(pin_s)
   );

   // Edge detection and decoded conditions.
   wire pd_ok = pin_s[SY_PD];
   wire jtag_mode = pin_s[SY_SEL];
   wire tck_rise = pin_s[SY_TCLK] & ~tclk_d_reg;
   wire tck_fall = ~pin_s[SY_TCLK] & tclk_d_reg;
   wire scl_rise = pin_s[SY_SCL] & ~scl_d_reg;
   wire scl_fall = ~pin_s[SY_SCL] & scl_d_reg;
   wire i2c_start = pin_s[SY_SCL] & scl_d_reg & ~pin_s[SY_SDA] & sda_d_reg;
   wire i2c_stop = pin_s[SY_SCL] & scl_d_reg & pin_s[SY_SDA] & ~sda_d_reg;
   wire jtag_rst = ~pin_s[SY_TRST] | ~jtag_mode;
   wire cfg_sel = (ir_reg == IR_CFG);
   wire jtag_cfg_upd = tck_rise & (tap_reg == TAP_UPDR) & cfg_sel;
   wire byte_done = (bcnt_reg == BIT_CNT_BYTE);
   wire [6:0] my_addr = {I2C_ADDR_HI, pin_s[SY_IDB], pin_s[SY_IDA]};
   wire addr_ok = (i2c_sh_reg[7:1] == my_addr) & ~i2c_sh_reg[0];
   wire i2c_cfg_wr = scl_fall & (i2c_reg == I2C_DATA) & byte_done & ~jtag_mode;
   wire bypass = ~pin_s[SY_LOOP] & cfg_reg[CFG_BYPASS];
   wire src_clk = bypass ? pin_s[SY_REF] : pin_s[SY_PLL];
   wire stopped = pin_s[SY_DIS] | ~pd_ok;
   wire gated = pin_s[SY_STOP] | cfg_reg[CFG_GATE];
   wire lvl = cfg_reg[CFG_LEVEL];
   wire shifting = (tap_reg == TAP_SHIR) | (tap_reg == TAP_SHDR);
   wire tdo_bit = (tap_reg == TAP_SHIR) ? ir_sh_reg[0] : (cfg_sel ? dr_sh_reg[0] : byp_reg);

   // Previous levels for edge detection.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         tclk_d_reg <= 1'b0;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         tclk_d_reg <= pin_s[SY_TCLK];
         scl_d_reg <= pin_s[SY_SCL];
         sda_d_reg <= pin_s[SY_SDA];
      end
   end

   // The controller steps on rising test clock; reset or serial mode forces the reset state.
   always_ff @(posedge mclk) begin
      if (!rstn || jtag_rst) begin
         tap_reg <= TAP_TLR;
      end else if (tck_rise) begin
         tap_reg <= ckd_tap_next(tap_reg, pin_s[SY_TMS]);
      end
   end

   // Instruction path: capture, shift least significant bit first, then update.
   always_ff @(posedge mclk) begin
      if (!rstn || jtag_rst || tap_reg == TAP_TLR) begin
         ir_sh_reg <= IR_CAPTURE;
         ir_reg <= IR_BYPASS;
      end else if (tck_rise) begin
         if (tap_reg == TAP_CAPIR) begin
            ir_sh_reg <= IR_CAPTURE;
         end else if (tap_reg == TAP_SHIR) begin
            ir_sh_reg <= {pin_s[SY_TDI], ir_sh_reg[IR_W-1:1]};
         end else if (tap_reg == TAP_UPIR) begin
            ir_reg <= ir_sh_reg;
         end
      end
   end

   // Data path: the configuration shifter or the single bypass bit.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         dr_sh_reg <= CFG_RST;
         byp_reg <= 1'b0;
      end else if (tck_rise && tap_reg == TAP_CAPDR) begin
         dr_sh_reg <= cfg_reg;
         byp_reg <= 1'b0;
      end else if (tck_rise && tap_reg == TAP_SHDR) begin
         dr_sh_reg <= {pin_s[SY_TDI], dr_sh_reg[CFG_W-1:1]};
         byp_reg <= pin_s[SY_TDI];
      end
   end

   // Scan data out moves only on falling test clock and floats outside the shift states.
   always_ff @(posedge mclk) begin
      if (!rstn || jtag_rst) begin
         tdo_out <= 1'b0;
         tdo_oe <= 1'b0;
      end else if (tck_fall) begin
         tdo_out <= tdo_bit;
         tdo_oe <= shifting;
      end
   end

   // Configuration register, written by whichever programming interface is selected.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         cfg_reg <= CFG_RST;
      end else if (jtag_cfg_upd) begin
         cfg_reg <= dr_sh_reg;
      end else if (i2c_cfg_wr) begin
         cfg_reg <= i2c_sh_reg[CFG_W-1:0];
      end
   end

   // Serial bus slave: address byte with acknowledge, then configuration data bytes.
   always_ff @(posedge mclk) begin
      if (!rstn || jtag_mode || i2c_stop) begin
         i2c_reg <= I2C_IDLE;
         bcnt_reg <= BIT_CNT_ZERO;
         i2c_sh_reg <= 8'h00;
         sda_oe <= 1'b0;
      end else if (i2c_start) begin
         i2c_reg <= I2C_ADDR;
         bcnt_reg <= BIT_CNT_ZERO;
         sda_oe <= 1'b0;
      end else if (scl_rise && (i2c_reg == I2C_ADDR || i2c_reg == I2C_DATA)) begin
         i2c_sh_reg <= {i2c_sh_reg[6:0], pin_s[SY_SDA]};
         bcnt_reg <= bcnt_reg + 4'h1;
      end else if (scl_fall) begin
         case (i2c_reg)
            I2C_ADDR: begin
               if (byte_done) begin
                  i2c_reg <= addr_ok ? I2C_ACKA : I2C_IDLE;
                  sda_oe <= addr_ok;
               end
            end
            I2C_DATA: begin
               if (byte_done) begin
                  i2c_reg <= I2C_ACKD;
                  sda_oe <= 1'b1;
               end
            end
            I2C_ACKA, I2C_ACKD: begin
               i2c_reg <= I2C_DATA;
               bcnt_reg <= BIT_CNT_ZERO;
               sda_oe <= 1'b0;
            end
            default: begin
               i2c_reg <= I2C_IDLE;
            end
         endcase
      end
   end

   // Clock outputs: running, gated to a level, or floating.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         true_clk_out <= 1'b0;
         inverted_clk_out <= 1'b1;
         feedback_clk_out <= 1'b0;
         feedback_inv_out <= 1'b1;
         clk_oe <= 1'b0;
      end else begin
         true_clk_out <= stopped ? ~lvl : src_clk;
         inverted_clk_out <= stopped ? lvl : ~src_clk;
         feedback_clk_out <= stopped ? ~lvl : src_clk;
         feedback_inv_out <= stopped ? lvl : ~src_clk;
         clk_oe <= ~stopped | gated;
      end
   end

   // Loop control, input enable and lock status.
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         pll_enable <= 1'b0;
         input_enable <= 1'b0;
         lock_out <= 1'b0;
         sda_out <= 1'b0;
         cfg_state <= CFG_RST;
      end else begin
         pll_enable <= ~bypass & pd_ok;
         input_enable <= pd_ok;
         lock_out <= pin_s[SY_LOCK] & ~bypass & pd_ok;
         sda_out <= 1'b0;
         cfg_state <= cfg_reg;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence addr_byte_s;
      (i2c_reg == I2C_ADDR) && scl_fall && byte_done && addr_ok && !jtag_mode
         && !i2c_stop && !i2c_start;
   endsequence
   sequence ack_drive_s;
      sda_oe && (i2c_reg == I2C_ACKA);
   endsequence

   bypass_sel_a: assert property (bypass |=> !pll_enable) else $error("loop not bypassed");
   pd_halt_a: assert property (!pd_ok |=> !pll_enable && !input_enable)
      else $error("power down did not halt");
   gated_drive_a: assert property (stopped && gated |=> clk_oe)
      else $error("gated stop not driven");
   gated_level_a: assert property (stopped && gated |=>
      true_clk_out == !$past(lvl) && inverted_clk_out == $past(lvl)
      && feedback_clk_out == !$past(lvl)) else $error("gated stop level wrong");
   tristate_a: assert property (stopped && !gated |=> !clk_oe)
      else $error("outputs not floated");
   lock_ind_a: assert property (!pin_s[SY_LOCK] |=> !lock_out)
      else $error("lock shown while unlocked");
   trst_reset_a: assert property (!pin_s[SY_TRST] |=> tap_reg == TAP_TLR)
      else $error("test reset ignored");
   sel_reset_a: assert property (!jtag_mode |=> tap_reg == TAP_TLR && !tdo_oe)
      else $error("scan active in bus mode");
   tdo_fall_a: assert property (!tck_fall && !jtag_rst |=> $stable(tdo_out))
      else $error("scan out moved off falling edge");
   tap_rise_a: assert property (!tck_rise && !jtag_rst |=> $stable(tap_reg))
      else $error("controller moved off rising edge");
   addr_ack_a: assert property (addr_byte_s |=> ack_drive_s)
      else $error("own address not acknowledged");
   cfg_write_a: assert property (jtag_cfg_upd |=> cfg_reg == $past(dr_sh_reg))
      else $error("configuration not updated");
endmodule : ckd_top

//--- verif/ckd_host_model.sv
// Behavioural programming host: drives the scan port and the serial bus and records answers.
`timescale 1ns/1ps
module ckd_host_model (
   // Pins driven by the host.
   output logic tclk,
   output logic tms,
   output logic tdi,
   output logic sda_pull_low,
   // Pins observed by the host.
   input wire logic tdo_out,
   input wire logic tdo_oe,
   input wire logic sda_line,
   // Answers recorded for the bench.
   output logic [3:0] tdo_cap,
   output logic oe_all,
   output logic [1:0] ack_cap
);
   import ckd_pkg::*;

   // The link clock stands low between scan frames.
   initial begin
      tclk = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      sda_pull_low = 1'b0;
      tdo_cap = 4'h0;
      oe_all = 1'b0;
      ack_cap = 2'b00;
   end

   // One test clock period; mode and data are set half a period before the rise.
   task automatic tck(input logic m, input logic d, output logic o, output logic e);
      tms = m;
      tdi = d;
      #80 tclk = 1'b1;
      #40 o = tdo_out;
      e = tdo_oe;
      #40 tclk = 1'b0;
   endtask : tck

   // Writes the configuration; with full low it stops after the first instruction bit.
   task automatic scan_cfg(input logic [2:0] v, input logic full);
      logic o;
      logic e;
      logic [9:0] walk;
      #7;
      walk = 10'h0df;
      oe_all = 1'b1;
      for (int i = 0; i < 10; i++) begin
         tck(walk[i], 1'b0, o, e);
      end
      for (int i = 0; i < 4; i++) begin
         tck(i == 3, IR_CFG[i], o, e);
         tdo_cap[i] = o;
         oe_all = oe_all & e;
         if (!full) begin
            return;
         end
      end
      walk = 10'h003;
      for (int i = 0; i < 4; i++) begin
         tck(walk[i], 1'b0, o, e);
      end
      for (int i = 0; i < 3; i++) begin
         tck(i == 2, v[i], o, e);
      end
      tck(1'b1, 1'b0, o, e);
      tck(1'b0, 1'b0, o, e);
   endtask : scan_cfg

   // Serial write of one address byte and one data byte; data changes while clock is low, except at the start and stop conditions.
   task automatic i2c_wr(input logic [7:0] a, input logic [7:0] d);
      logic [15:0] bits;
      #7;
      bits = {a, d};
      ack_cap = 2'b00;
      tclk = 1'b1;
      sda_pull_low = 1'b0;
      #160 sda_pull_low = 1'b1;
      #80 tclk = 1'b0;
      // The slave sees the clock through its synchroniser and moves the line some system
      // cycles after the falling edge, so the low phase is long enough for that to settle.
      for (int i = 15; i >= 0; i--) begin
         #40 sda_pull_low = !bits[i];
         #120 tclk = 1'b1;
         #80 tclk = 1'b0;
         if (i % 8 == 0) begin
            #40 sda_pull_low = 1'b0;
            #120 tclk = 1'b1;
            #40 ack_cap[i / 8] = !sda_line;
            #40 tclk = 1'b0;
         end
      end
      #40 sda_pull_low = 1'b1;
      #40 tclk = 1'b1;
      #80 sda_pull_low = 1'b0;
      #80;
   endtask : i2c_wr
endmodule : ckd_host_model

//--- verif/tb_top.sv
// Self-checking bench of the clock driver control: pin logic, scan and serial programming.
`timescale 1ns/1ps
module tb_top;
   import ckd_pkg::*;
   // Expected result noted by the driver, compared later by the monitor.
   typedef struct {
      string name;
      logic [20:0] mask;
      logic [20:0] val;
   } ckd_note_s;
   ckd_note_s notes[$];
   ckd_note_s cur;
   logic mclk;
   logic rstn;
   logic [6:0] pins;   // Reference, loop clock, locked, disable, style, power up, loop enable.
   logic trst_n;
   logic if_sel;
   logic bus_b;
   logic bus_a;
   logic chk_req;      // Strobe telling the monitor that a result is due.
   logic [31:0] rnd;
   logic [20:0] ev;
   int n_mismatch;
   int total_checks;
   logic tclk, tms, tdi, sda_pull_low, tdo_out, tdo_oe, sda_out, sda_oe, oe_all;
   logic true_clk_out, inverted_clk_out, feedback_clk_out, feedback_inv_out, clk_oe;
   logic pll_enable, input_enable, lock_out;
   logic [2:0] cfg_state;
   logic [3:0] tdo_cap;
   logic [1:0] ack_cap;
   logic [20:0] obs;
   // The serial data line has a pull-up; either party may pull it low.
   wire logic sda_line = !sda_pull_low & (sda_oe ? sda_out : 1'b1);
   assign obs = {oe_all, tdo_cap, ack_cap, cfg_state, lock_out, input_enable, pll_enable,
      clk_oe, feedback_inv_out, feedback_clk_out, inverted_clk_out, true_clk_out, sda_oe,
      tdo_oe, tdo_out};

   ckd_top i_ckd_top (.mclk(mclk), .rstn(rstn), .loop_enable(pins[0]),
      .power_down_n(pins[1]), .stop_style_ctl(pins[2]), .out_disable(pins[3]),
      .ref_clk(pins[6]), .pll_clk(pins[5]), .pll_locked(pins[4]), .trst_n(trst_n),
      .if_sel(if_sel), .tclk(tclk), .tms(tms), .tdi(tdi), .bus_id_pin_b(bus_b),
      .bus_id_pin_a(bus_a), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .true_clk_out(true_clk_out),
      .inverted_clk_out(inverted_clk_out), .feedback_clk_out(feedback_clk_out),
      .feedback_inv_out(feedback_inv_out), .clk_oe(clk_oe), .pll_enable(pll_enable),
      .input_enable(input_enable), .lock_out(lock_out), .cfg_state(cfg_state));

   ckd_host_model i_ckd_host_model (.tclk(tclk), .tms(tms), .tdi(tdi),
      .sda_pull_low(sda_pull_low), .tdo_out(tdo_out), .tdo_oe(tdo_oe), .sda_line(sda_line),
      .tdo_cap(tdo_cap), .oe_all(oe_all), .ack_cap(ack_cap));

   // Clock of 20 ns period.
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   // Pseudo-random source for the board pins.
   function automatic logic [31:0] ckd_xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction : ckd_xs

   // Expected output vector for given pins and configuration.
   function automatic logic [20:0] exp_pins(input logic [6:0] p, input logic [2:0] c);
      logic byp;
      logic stp;
      logic src;
      logic [20:0] e;
      byp = !p[0] & c[0];
      stp = p[3] | !p[1];
      src = byp ? p[6] : p[5];
      e = 21'h000000;
      e[13:11] = c;
      e[10] = p[4] & !byp & p[1];
      e[9] = p[1];
      e[8] = !byp & p[1];
      e[7] = !stp | p[2] | c[2];
      e[6] = stp ? c[1] : !src;
      e[5] = stp ? !c[1] : src;
      e[4] = e[6];
      e[3] = e[5];
      return e;
   endfunction : exp_pins

   // Notes an expectation and strobes the monitor for one cycle.
   task automatic note(input string nm, input logic [20:0] m, input logic [20:0] v);
      notes.push_back('{nm, m, v});
      @(posedge mclk) chk_req <= 1'b1;
      @(posedge mclk) chk_req <= 1'b0;
   endtask : note

   // Monitor: the oldest note is compared with the settled outputs on each strobe.
   always @(negedge mclk) begin
      if (chk_req === 1'b1 && notes.size() > 0) begin
         cur = notes.pop_front();
         total_checks++;
         if ((obs & cur.mask) !== (cur.val & cur.mask)) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", cur.name, cur.val & cur.mask,
               obs & cur.mask);
         end
      end
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   // Watchdog cuts a hang short.
   initial begin
      repeat (100000) @(posedge mclk);
      n_mismatch++;
      give_verdict();
   end

   // Main sequence.
   initial begin
      rstn = 1'b0;
      pins = 7'h07;
      trst_n = 1'b1;
      if_sel = 1'b1;
      bus_b = 1'b0;
      bus_a = 1'b0;
      chk_req = 1'b0;
      rnd = 32'h44b8207c;
      n_mismatch = 0;
      total_checks = 0;
      repeat (2) @(posedge mclk);
      note("reset", 21'h003fff, 21'h000050);
      rstn <= 1'b1;
      repeat (10) @(posedge mclk);
      // Every configuration value through the scan port, then random pin settings.
      for (int c = 0; c < 8; c++) begin
         pins <= 7'h07;
         repeat (10) @(posedge mclk);
         i_ckd_host_model.scan_cfg(c[2:0], 1'b1);
         @(posedge mclk);
         note("scan", 21'h1f3802, {1'b1, IR_CAPTURE, 2'b00, c[2:0], 11'h000});
         for (int k = 0; k < 4; k++) begin
            rnd = ckd_xs(rnd);
            pins <= rnd[6:0];
            repeat (10) @(posedge mclk);
            ev = exp_pins(rnd[6:0], c[2:0]);
            note("pins", ev[7] ? 21'h003ff8 : 21'h003f88, ev);
         end
      end
      $display("test scan_and_pins done");
      // Test reset and interface select abort a shift in progress.
      pins <= 7'h07;
      for (int k = 0; k < 2; k++) begin
         i_ckd_host_model.scan_cfg(3'h5, 1'b0);
         @(posedge mclk);
         if (k == 0) begin
            trst_n <= 1'b0;
         end else begin
            if_sel <= 1'b0;
         end
         repeat (10) @(posedge mclk);
         note("abort", 21'h003802, 21'h003800);
         trst_n <= 1'b1;
         if_sel <= 1'b1;
         repeat (10) @(posedge mclk);
      end
      i_ckd_host_model.scan_cfg(3'h2, 1'b1);
      // The update reaches the status copy a few system cycles after the last test clock.
      repeat (4) @(posedge mclk);
      note("rescan", 21'h003802, 21'h001000);
      $display("test abort done");
      // Serial writes: own address, other address, then a read request.
      if_sel <= 1'b0;
      rnd = ckd_xs(rnd);
      bus_b <= rnd[8];
      bus_a <= rnd[9];
      repeat (10) @(posedge mclk);
      for (int k = 0; k < 3; k++) begin
         i_ckd_host_model.i2c_wr({I2C_ADDR_HI, rnd[8] ^ (k == 1), rnd[9], k == 2},
            (k == 0) ? rnd[23:16] : ~rnd[23:16]);
         @(posedge mclk);
         note("serial", 21'h00f804,
            {5'h00, ((k == 0) ? 2'b11 : 2'b00), rnd[18:16], 11'h000});
      end
      $display("test serial done");
      give_verdict();
   end
endmodule : tb_top
